// ===== rtl/flash_map.sv
// Address-space map and access policy core of a 32-Mbit serial flash
`timescale 1ns/1ps
`default_nettype none
module flash_map #(
    parameter logic [7:0] VENDOR_ID = 8'hA5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire logic [7:0] req_opcode,
    input wire logic [23:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [2:0] lock_set,
    output logic busy,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [7:0] rsp_data,
    output logic [2:0] lock_state
);
    import flash_map_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_WRITE} state_t;

    // Header bytes; everything else, including the reserved holes, reads FFh
    function automatic logic [7:0] param_byte(input logic [7:0] a);
        unique case (a)
            HDR_START: param_byte = SIG_S;
            8'h01: param_byte = SIG_F;
            8'h02: param_byte = SIG_D;
            8'h03: param_byte = SIG_P;
            8'h04: param_byte = 8'h08;
            8'h05: param_byte = 8'h01;
            8'h06: param_byte = 8'h01;
            8'h08: param_byte = 8'h00;
            8'h09: param_byte = 8'h07;
            8'h0A: param_byte = 8'h01;
            8'h0B: param_byte = 8'h10;
            PTR_ADDR: param_byte = BASIC_START;
            8'h0D: param_byte = 8'h00;
            8'h0E: param_byte = 8'h00;
            8'h10: param_byte = VENDOR_ID;
            8'h11: param_byte = 8'h00;
            8'h12: param_byte = 8'h01;
            default: param_byte = ERASED_BYTE;
        endcase
    endfunction

    decode_if dif ();
    addr_decode u_dec (
        .dif(dif)
    );
    assign dif.opcode = req_opcode;
    assign dif.addr = req_addr;

    // Array storage carries no reset; reset sets blank_r and sec_blank_r, so contents read FFh after it
    logic [7:0] main_mem [0:MAIN_BYTES-1];
    logic [7:0] sec_mem [0:4*SEC_BYTES-1];

    state_t state_r, state_nxt;
    logic [11:0] fill_cnt_r, fill_cnt_nxt;
    logic [21:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic sec_r, sec_nxt;
    logic [SECTORS-1:0] blank_r, blank_nxt;
    logic [3:0] sec_blank_r, sec_blank_nxt;
    logic [3:0] lock_r, lock_nxt;
    logic busy_r, rsp_valid_r, rsp_ok_r;
    logic [7:0] rsp_data_r, rsp_data_nxt;
    logic rsp_valid_nxt, rsp_ok_nxt;
    logic main_we, sec_we;
    logic [21:0] main_wa;
    logic [11:0] sec_wa;
    logic [7:0] wd, old_byte;
    logic take;
    logic [1:0] idx_r;
    logic [11:0] fill_last;

    assign idx_r = addr_r[SIDX_HI:SIDX_LO];
    assign take = req_valid && (state_r == ST_IDLE);
    assign fill_last = sec_r ? SEC_LAST : SECT_LAST;

    always_comb begin
        state_nxt = state_r;
        fill_cnt_nxt = fill_cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        sec_nxt = sec_r;
        blank_nxt = blank_r;
        sec_blank_nxt = sec_blank_r;
        lock_nxt = lock_r | {lock_set, 1'b0};
        rsp_valid_nxt = 1'b0;
        rsp_ok_nxt = 1'b0;
        rsp_data_nxt = ERASED_BYTE;
        main_we = 1'b0;
        sec_we = 1'b0;
        main_wa = addr_r;
        sec_wa = {idx_r, addr_r[SOFF_HI:0]};
        wd = ERASED_BYTE;
        old_byte = ERASED_BYTE;
        unique case (state_r)
            ST_IDLE: begin
                if (take) begin
                    addr_nxt = req_addr[MAIN_HI:0];
                    wdata_nxt = req_wdata;
                    sec_nxt = (dif.kind == K_SEC_PROG);
                    fill_cnt_nxt = 12'h000;
                    rsp_valid_nxt = 1'b1;
                    rsp_ok_nxt = dif.in_range;
                    unique case (dif.kind)
                        K_READ: begin
                            if (dif.in_range && !blank_r[dif.sector]) begin
                                rsp_data_nxt = main_mem[req_addr[MAIN_HI:0]];
                            end
                        end
                        K_SEC_READ: begin
                            if (dif.in_range && dif.sec_idx == 2'h0) begin
                                rsp_data_nxt = param_byte(req_addr[POFF_HI:0]);
                            end else if (dif.in_range && !sec_blank_r[dif.sec_idx]) begin
                                rsp_data_nxt = sec_mem[{dif.sec_idx, req_addr[SOFF_HI:0]}];
                            end
                        end
                        K_PARAM_READ: begin
                            rsp_ok_nxt = 1'b1;
                            if (req_addr[23:POFF_HI+1] == 16'h0000) begin
                                rsp_data_nxt = param_byte(req_addr[POFF_HI:0]);
                            end
                        end
                        K_PROG: begin
                            if (dif.in_range) begin
                                rsp_valid_nxt = 1'b0;
                                state_nxt = blank_r[dif.sector] ? ST_FILL : ST_WRITE;
                            end
                        end
                        K_SEC_PROG: begin
                            // Register 0 is locked from reset onward; lock_state does not show it
                            if (!dif.in_range || lock_r[dif.sec_idx]) begin
                                rsp_ok_nxt = 1'b0;
                            end else begin
                                rsp_valid_nxt = 1'b0;
                                state_nxt = sec_blank_r[dif.sec_idx] ? ST_FILL : ST_WRITE;
                            end
                        end
                        K_ERASE_SECT: begin
                            if (dif.in_range) begin
                                blank_nxt[dif.sector] = 1'b1;
                            end
                        end
                        K_ERASE_BLK: begin
                            if (dif.in_range) begin
                                for (int i = 0; i < SECT_PER_BLK; i++) begin
                                    blank_nxt[{req_addr[MAIN_HI:BLK_LO], 4'(i)}] = 1'b1;
                                end
                            end
                        end
                        K_ERASE_CHIP: begin
                            rsp_ok_nxt = 1'b1;
                            blank_nxt = '1;
                        end
                        K_SEC_ERASE: begin
                            if (!dif.in_range || lock_r[dif.sec_idx]) begin
                                rsp_ok_nxt = 1'b0;
                            end else begin
                                sec_blank_nxt[dif.sec_idx] = 1'b1;
                            end
                        end
                        default: rsp_ok_nxt = 1'b0;
                    endcase
                end
            end
            ST_FILL: begin
                // Blank areas are only flagged on erase; bytes are filled with FFh on first program
                main_we = !sec_r;
                sec_we = sec_r;
                main_wa = {addr_r[MAIN_HI:SECT_LO], fill_cnt_r};
                sec_wa = {idx_r, fill_cnt_r[SOFF_HI:0]};
                fill_cnt_nxt = fill_cnt_r + 12'h001;
                if (fill_cnt_r == fill_last) begin
                    if (sec_r) begin
                        sec_blank_nxt[idx_r] = 1'b0;
                    end else begin
                        blank_nxt[addr_r[MAIN_HI:SECT_LO]] = 1'b0;
                    end
                    state_nxt = ST_WRITE;
                end
            end
            ST_WRITE: begin
                main_we = !sec_r;
                sec_we = sec_r;
                old_byte = sec_r ? sec_mem[sec_wa] : main_mem[main_wa];
                wd = wdata_r & old_byte;
                rsp_valid_nxt = 1'b1;
                rsp_ok_nxt = 1'b1;
                rsp_data_nxt = wd;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (main_we) begin
            main_mem[main_wa] <= wd;
        end
        if (sec_we) begin
            sec_mem[sec_wa] <= wd;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            fill_cnt_r <= 12'h000;
            addr_r <= 22'h00_0000;
            wdata_r <= ERASED_BYTE;
            sec_r <= 1'b0;
            blank_r <= '1;
            sec_blank_r <= 4'hF;
            lock_r <= LOCK_RST;
            busy_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_ok_r <= 1'b0;
            rsp_data_r <= ERASED_BYTE;
        end else begin
            state_r <= state_nxt;
            fill_cnt_r <= fill_cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            sec_r <= sec_nxt;
            blank_r <= blank_nxt;
            sec_blank_r <= sec_blank_nxt;
            lock_r <= lock_nxt;
            busy_r <= (state_nxt != ST_IDLE);
            rsp_valid_r <= rsp_valid_nxt;
            rsp_ok_r <= rsp_ok_nxt;
            rsp_data_r <= rsp_data_nxt;
        end
    end

    assign busy = busy_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_ok = rsp_ok_r;
    assign rsp_data = rsp_data_r;
    assign lock_state = lock_r[3:1];

    a_sig_first: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_PARAM_READ && req_addr == 24'h00_0000
        |=> rsp_valid && rsp_ok && rsp_data == SIG_S)
        else $error("Signature byte wrong");
    a_table_ptr: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_PARAM_READ && req_addr == {16'h0000, PTR_ADDR}
        |=> rsp_data == BASIC_START)
        else $error("Table pointer wrong");
    a_reserved_read: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_PARAM_READ && req_addr[POFF_HI:0] >= RSV_START
        |=> rsp_valid && rsp_ok && rsp_data == ERASED_BYTE)
        else $error("Reserved read not fixed");
    a_param_protect: assert property (@(posedge clk) disable iff (!resetn)
        take && (dif.kind == K_SEC_PROG || dif.kind == K_SEC_ERASE) && dif.sec_idx == 2'h0
        |=> rsp_valid && !rsp_ok && !busy)
        else $error("Parameter region altered");
    a_lock_block: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_SEC_PROG && lock_r[dif.sec_idx]
        |=> rsp_valid && !rsp_ok ##1 !busy)
        else $error("Locked register programmed");
    a_no_page_erase: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_NONE |=> rsp_valid && !rsp_ok)
        else $error("Unknown command accepted");
    a_blank_read: assert property (@(posedge clk) disable iff (!resetn)
        take && dif.kind == K_READ && dif.in_range && blank_r[dif.sector]
        |=> rsp_data == ERASED_BYTE)
        else $error("Erased byte not FFh");
    a_prog_clear: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ST_WRITE |=> rsp_valid && (rsp_data & ~$past(wdata_r)) == 8'h00 &&
            (rsp_data & ~$past(old_byte)) == 8'h00)
        else $error("Program set a bit");
    a_lock_sticky: assert property (@(posedge clk) disable iff (!resetn)
        $past(lock_state) != 3'h0 |-> (lock_state & $past(lock_state)) == $past(lock_state))
        else $error("Lock bit cleared");
endmodule // flash_map
`default_nettype wire

// ===== rtl/flash_map_pkg.sv
// Geometry, opcodes and discoverable-parameter constants of the flash address map
package flash_map_pkg;
    localparam int MAIN_BYTES = 4194304;
    localparam int BLOCKS = 64;
    localparam int SECTORS = 1024;
    localparam int SECT_PER_BLK = 16;
    localparam int PAGES = 16384;
    localparam int PAGE_BYTES = 256;
    localparam int SECT_BYTES = 4096;
    localparam int SEC_BYTES = 1024;
    localparam int PARAM_BYTES = 256;

    // Address field positions
    localparam int MAIN_HI = 21;
    localparam int SECT_LO = 12;
    localparam int BLK_LO = 16;
    localparam int SIDX_HI = 13;
    localparam int SIDX_LO = 12;
    localparam int SOFF_HI = 9;
    localparam int POFF_HI = 7;
    localparam int SEC0_HI = 11;

    localparam logic [11:0] SECT_LAST = 12'hFFF;
    localparam logic [11:0] SEC_LAST = 12'h3FF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] LOCK_RST = 4'h1;

    // Command opcodes
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_PROG = 8'h02;
    localparam logic [7:0] OPC_ERASE_SECT = 8'h20;
    localparam logic [7:0] OPC_ERASE_BLK = 8'hD8;
    localparam logic [7:0] OPC_ERASE_CHIP = 8'hC7;
    localparam logic [7:0] OPC_SEC_READ = 8'h48;
    localparam logic [7:0] OPC_SEC_PROG = 8'h42;
    localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
    localparam logic [7:0] OPC_PARAM_READ = 8'h5A;

    // Discoverable-parameter space layout and header bytes
    localparam logic [7:0] HDR_START = 8'h00;
    localparam logic [7:0] HDR_RSV_START = 8'h20;
    localparam logic [7:0] BASIC_START = 8'h30;
    localparam logic [7:0] PARAM_END = 8'h7B;
    localparam logic [7:0] RSV_START = 8'h7C;
    localparam logic [7:0] SIG_S = 8'h53;
    localparam logic [7:0] SIG_F = 8'h46;
    localparam logic [7:0] SIG_D = 8'h44;
    localparam logic [7:0] SIG_P = 8'h50;
    localparam logic [7:0] PTR_ADDR = 8'h0C;

    typedef enum logic [3:0] {
        K_NONE, K_READ, K_PROG, K_ERASE_SECT, K_ERASE_BLK, K_ERASE_CHIP,
        K_SEC_READ, K_SEC_PROG, K_SEC_ERASE, K_PARAM_READ
    } kind_t;
endpackage

// ===== rtl/decode_if.sv
// Decoded command and address fields passed from the decoder to the core
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import flash_map_pkg::*;
    logic [7:0] opcode;
    logic [23:0] addr;
    kind_t kind;
    logic in_range;
    logic [9:0] sector;
    logic [1:0] sec_idx;
    modport dec (input opcode, addr, output kind, in_range, sector, sec_idx);
    modport core (output opcode, addr, input kind, in_range, sector, sec_idx);
endinterface
`default_nettype wire

// ===== rtl/addr_decode.sv
// Opcode and address decoder for main array, security and parameter spaces
`timescale 1ns/1ps
`default_nettype none
module addr_decode (
    decode_if.dec dif
);
    import flash_map_pkg::*;

    always_comb begin
        dif.sector = dif.addr[MAIN_HI:SECT_LO];
        dif.sec_idx = dif.addr[SIDX_HI:SIDX_LO];
        unique case (dif.opcode)
            OPC_READ: dif.kind = K_READ;
            OPC_PROG: dif.kind = K_PROG;
            OPC_ERASE_SECT: dif.kind = K_ERASE_SECT;
            OPC_ERASE_BLK: dif.kind = K_ERASE_BLK;
            OPC_ERASE_CHIP: dif.kind = K_ERASE_CHIP;
            OPC_SEC_READ: dif.kind = K_SEC_READ;
            OPC_SEC_PROG: dif.kind = K_SEC_PROG;
            OPC_SEC_ERASE: dif.kind = K_SEC_ERASE;
            OPC_PARAM_READ: dif.kind = K_PARAM_READ;
            default: dif.kind = K_NONE;
        endcase
        unique case (dif.kind)
            K_READ, K_PROG, K_ERASE_SECT, K_ERASE_BLK, K_ERASE_CHIP: begin
                dif.in_range = (dif.addr[23:MAIN_HI+1] == 2'h0);
            end
            K_SEC_READ, K_SEC_PROG, K_SEC_ERASE: begin
                // Register 0 spans one page only, the others a full 1024 bytes
                dif.in_range = (dif.addr[23:SIDX_HI+1] == 10'h000) &&
                    ((dif.sec_idx == 2'h0) ? (dif.addr[SEC0_HI:POFF_HI+1] == 4'h0)
                                           : (dif.addr[SEC0_HI:SOFF_HI+1] == 2'h0));
            end
            default: dif.in_range = 1'b1;
        endcase
    end
endmodule // addr_decode
`default_nettype wire

// ===== verification/host_model.sv
// Host-side request driver facing the flash map core
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic rsp_valid,
    input wire logic rsp_ok,
    input wire logic [7:0] rsp_data,
    output logic req_valid,
    output logic [7:0] req_opcode,
    output logic [23:0] req_addr,
    output logic [7:0] req_wdata
);
    logic got_ok;
    logic [7:0] got_data;
    int lat;
    int busy_cnt;

    initial begin
        req_valid = 1'b0;
        req_opcode = 8'h00;
        req_addr = 24'h00_0000;
        req_wdata = 8'h00;
    end

    // One byte per request; released fields are inverted so stale values never pass
    task automatic xfer(input logic [7:0] opc, input logic [23:0] a, input logic [7:0] wd);
        @(posedge clk);
        req_valid <= 1'b1;
        req_opcode <= opc;
        req_addr <= a;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        req_opcode <= ~opc;
        req_addr <= ~a;
        req_wdata <= ~wd;
        lat = 0;
        busy_cnt = 0;
        got_ok = 1'bx;
        got_data = 8'hxx;
        // Latency counts cycles after the take edge, so a one-cycle answer reads as 1
        while (lat < 5000) begin
            @(negedge clk);
            lat++;
            if (rsp_valid === 1'b1) begin
                got_ok = rsp_ok;
                got_data = rsp_data;
                break;
            end
            busy_cnt += (busy === 1'b1);
        end
    endtask
endmodule // host_model
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the flash address map core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_map_pkg::*;
    localparam logic [7:0] VENDOR_VAL = 8'h3C; // Arbitrary value
    localparam int FILL_MAIN = SECT_BYTES + 2;
    localparam int FILL_SEC = SEC_BYTES + 2;
    logic clk;
    logic resetn;
    logic [2:0] lock_set;
    logic req_valid;
    logic [7:0] req_opcode;
    logic [23:0] req_addr;
    logic [7:0] req_wdata;
    logic busy;
    logic rsp_valid;
    logic rsp_ok;
    logic [7:0] rsp_data;
    logic [2:0] lock_state;
    int n_fail = 0;
    int checked = 0;

    flash_map #(.VENDOR_ID(VENDOR_VAL)) dut_u (.clk(clk), .resetn(resetn),
        .req_valid(req_valid), .req_opcode(req_opcode), .req_addr(req_addr),
        .req_wdata(req_wdata), .lock_set(lock_set), .busy(busy), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_data(rsp_data), .lock_state(lock_state));
    host_model host_u (.clk(clk), .busy(busy), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_data(rsp_data), .req_valid(req_valid), .req_opcode(req_opcode),
        .req_addr(req_addr), .req_wdata(req_wdata));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Latency and busy span both judged: busy covers all answer cycles but the last
    task automatic op(input logic [7:0] opc, input logic [23:0] a, input logic [7:0] wd,
                      input logic eok, input logic [7:0] ed, input int elat);
        host_u.xfer(opc, a, wd);
        check({15'h0000, host_u.got_ok}, {15'h0000, eok}, "ok");
        check({8'h00, host_u.got_data}, {8'h00, ed}, "data");
        check(16'(host_u.lat), 16'(elat), "latency");
        check(16'(host_u.busy_cnt), 16'(elat - 1), "busy span");
    endtask

    task automatic quick(input logic [7:0] opc, input logic [23:0] a, input logic [7:0] ed);
        op(opc, a, 8'h00, 1'b1, ed, 1);
    endtask

    task automatic rj(input logic [7:0] opc, input logic [23:0] a);
        op(opc, a, 8'h00, 1'b0, 8'hFF, 1);
    endtask

    task automatic t_reset();
        @(negedge clk);
        check({15'h0000, busy}, 16'h0000, "busy");
        check({15'h0000, rsp_valid}, 16'h0000, "rsp_valid");
        check({13'h0000, lock_state}, 16'h0000, "locks");
        quick(OPC_READ, 24'h00_0000, 8'hFF);
        quick(OPC_READ, 24'h3F_FFFF, 8'hFF);
        rj(OPC_READ, 24'h40_0000);
    endtask

    task automatic t_program();
        op(OPC_PROG, 24'h00_0010, 8'hA5, 1'b1, 8'hA5, FILL_MAIN);
        op(OPC_PROG, 24'h00_0010, 8'h5A, 1'b1, 8'h00, 2);
        op(OPC_PROG, 24'h00_0010, 8'hFF, 1'b1, 8'h00, 2);
        op(OPC_PROG, 24'h00_0110, 8'h3C, 1'b1, 8'h3C, 2);
        quick(OPC_READ, 24'h00_0010, 8'h00);
        quick(OPC_READ, 24'h00_0111, 8'hFF);
    endtask

    task automatic t_erase();
        quick(OPC_ERASE_SECT, 24'h00_0123, 8'hFF);
        quick(OPC_READ, 24'h00_0010, 8'hFF);
        op(OPC_PROG, 24'h00_0FFF, 8'h12, 1'b1, 8'h12, FILL_MAIN);
        op(OPC_PROG, 24'h00_1000, 8'h34, 1'b1, 8'h34, FILL_MAIN);
        quick(OPC_ERASE_SECT, 24'h00_0000, 8'hFF);
        quick(OPC_READ, 24'h00_0FFF, 8'hFF);
        quick(OPC_READ, 24'h00_1000, 8'h34);
        op(OPC_PROG, 24'h01_0000, 8'h77, 1'b1, 8'h77, FILL_MAIN);
        quick(OPC_ERASE_BLK, 24'h00_F000, 8'hFF);
        quick(OPC_READ, 24'h00_1000, 8'hFF);
        quick(OPC_READ, 24'h01_0000, 8'h77);
        quick(OPC_ERASE_CHIP, 24'h12_3456, 8'hFF);
        quick(OPC_READ, 24'h01_0000, 8'hFF);
        rj(8'h81, 24'h00_0100);
    endtask

    task automatic t_security();
        quick(OPC_SEC_READ, 24'h00_1005, 8'hFF);
        op(OPC_SEC_PROG, 24'h00_1005, 8'h0F, 1'b1, 8'h0F, FILL_SEC);
        op(OPC_SEC_PROG, 24'h00_23FF, 8'hAA, 1'b1, 8'hAA, FILL_SEC);
        quick(OPC_READ, 24'h00_1005, 8'hFF);
        rj(OPC_SEC_READ, 24'h00_1400);
        quick(OPC_SEC_ERASE, 24'h00_1000, 8'hFF);
        quick(OPC_SEC_READ, 24'h00_1005, 8'hFF);
        quick(OPC_SEC_READ, 24'h00_23FF, 8'hAA);
        op(OPC_SEC_PROG, 24'h00_1005, 8'h0F, 1'b1, 8'h0F, FILL_SEC);
        @(posedge clk);
        lock_set <= 3'b001;
        @(posedge clk);
        lock_set <= 3'b000;
        @(negedge clk);
        check({13'h0000, lock_state}, 16'h0001, "lock one");
        rj(OPC_SEC_PROG, 24'h00_1005);
        rj(OPC_SEC_ERASE, 24'h00_1000);
        quick(OPC_SEC_READ, 24'h00_1005, 8'h0F);
        op(OPC_SEC_PROG, 24'h00_23FE, 8'h55, 1'b1, 8'h55, 2);
        quick(OPC_SEC_ERASE, 24'h00_3000, 8'hFF);
        @(posedge clk);
        lock_set <= 3'b110;
        @(posedge clk);
        lock_set <= 3'b000;
        repeat (3) @(negedge clk);
        check({13'h0000, lock_state}, 16'h0007, "locks sticky");
    endtask

    task automatic t_params();
        logic [7:0] sig [4] = '{SIG_S, SIG_F, SIG_D, SIG_P};
        for (int i = 0; i < 4; i++) begin
            quick(OPC_PARAM_READ, {16'h0000, 8'(i)}, sig[i]);
        end
        quick(OPC_PARAM_READ, 24'h00_000C, BASIC_START);
        quick(OPC_PARAM_READ, 24'h00_000C, 8'h30);
        quick(OPC_PARAM_READ, 24'h00_0010, VENDOR_VAL);
        quick(OPC_PARAM_READ, 24'h00_0020, 8'hFF);
        quick(OPC_PARAM_READ, 24'h00_007C, 8'hFF);
        quick(OPC_PARAM_READ, 24'h00_00FF, 8'hFF);
        quick(OPC_PARAM_READ, 24'h00_0100, 8'hFF);
        quick(OPC_SEC_READ, 24'h00_0000, SIG_S);
        quick(OPC_SEC_READ, 24'h00_0003, SIG_P);
        rj(OPC_SEC_PROG, 24'h00_0000);
        rj(OPC_SEC_ERASE, 24'h00_0000);
        quick(OPC_PARAM_READ, 24'h00_0000, SIG_S);
        quick(OPC_READ, 24'h00_0000, 8'hFF);
    endtask

    // Mid-run reset: locks drop and security registers read erased again
    task automatic t_rerun();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({13'h0000, lock_state}, 16'h0000, "locks after reset");
        check({15'h0000, busy}, 16'h0000, "busy after reset");
        quick(OPC_SEC_READ, 24'h00_23FF, 8'hFF);
        op(OPC_SEC_PROG, 24'h00_1005, 8'hC3, 1'b1, 8'hC3, FILL_SEC);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Longest path is a handful of sector fills; allow generous margin
    initial begin
        #(80000 * 8);
        n_fail++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        lock_set = 3'b000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_program();
        t_erase();
        t_security();
        t_params();
        t_rerun();
        end_sim();
    end
endmodule // tb
`default_nettype wire
